// *** bench/board_reset_source.sv ***
// Board reset source: pulled-up soft line, driven hard line.
// The bench sets hs and hh; the device's drive pulls sp low.
`timescale 1ns/10ps
module board_reset_source (
	input wire logic hs,
	input wire logic hh,
	input wire logic oe,
	input wire logic out,
	output logic sp,
	output logic hp
);
	assign sp = !(hs || (oe && !out));
	assign hp = !hh;
endmodule : board_reset_source

// *** bench/reset_ctrl_assertions.sv ***
// Port checker for the reset controller.
// Bound to the reset controller module.
`timescale 1ns/10ps
module reset_ctrl_checker (
	input wire logic clk, reset_n, soft_reset_pin_n_in, soft_reset_pin_n_out,
	input wire logic soft_reset_pin_n_oe, hard_power_reset_pin_n, run,
	input wire reset_ctrl_pkg::reset_group_t reset_out
);
	wire p = soft_reset_pin_n_in, h = hard_power_reset_pin_n, o = soft_reset_pin_n_oe;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence burst; o [*6] ##1 !o [*3]; endsequence
	a_burst_len: assert property ($rose(o) |-> burst) else $error("burst");
	a_out_zero: assert property (o |-> !soft_reset_pin_n_out) else $error("out");
	a_oe_sync: assert property ($rose(o) |-> !$past(p, 3)) else $error("sync");
	a_soft_hold: assert property (!p [*4] |-> reset_out.core) else $error("hold");
	a_hard_hold: assert property (!h [*4] |-> reset_out == 4'hF && !o) else $error("hard");
	a_por_kept: assert property (h [*5] |-> !reset_out.por_only) else $error("por");
	a_run_clean: assert property (run |-> reset_out == 4'h0) else $error("run");
	a_grp_tied: assert property (reset_out.core == reset_out.periph) else $error("grp");
endmodule : reset_ctrl_checker
bind dual_pin_reset_controller reset_ctrl_checker chk (.*);

// *** bench/tb_dual_pin_reset_controller.sv ***
// Reset controller bench.
// Drives the board source model at falling edges.
`timescale 1ns/10ps
module tb_dual_pin_reset_controller;
	logic clk = 0, reset_n = 0, hs = 0, hh = 0, oe, out, sp, hp, run;
	reset_ctrl_pkg::reset_group_t ro;
	int n_mismatch = 0, comparisons = 0;
	always #5 clk = !clk;
	board_reset_source src (.hs, .hh, .oe, .out, .sp, .hp);
	dual_pin_reset_controller uut (.clk, .reset_n, .soft_reset_pin_n_in(sp),
		.soft_reset_pin_n_out(out), .soft_reset_pin_n_oe(oe),
		.hard_power_reset_pin_n(hp), .reset_out(ro), .run);
	task w(int n);
		repeat (n) @(negedge clk);
	endtask : w
	task chk(string s, logic [4:0] e);
		comparisons++;
		n_mismatch += ({ro, run} !== e);
		if ({ro, run} !== e)
			$display("[ERR] %s exp %h got %h", s, e, {ro, run});
	endtask : chk
	task chk_pin(string s, logic [1:0] e);
		comparisons++;
		n_mismatch += ({oe, out} !== e);
		if ({oe, out} !== e)
			$display("[ERR] %s exp %h got %h", s, e, {oe, out});
	endtask : chk_pin
	task chk_n(string s, int e, int g);
		comparisons++;
		n_mismatch += (g != e);
		if (g != e)
			$display("[ERR] %s exp %0d got %0d", s, e, g);
	endtask : chk_n
	task stop_test;
		if (n_mismatch == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	task t_soft;
		int n;
		hs = 1;
		w(3);
		chk_pin("drive", 2'h2);
		n = 0;
		while (oe === 1'b1 && n < 20)
		begin
			n++;
			w(1);
		end
		chk_n("burst", 6, n);
		w(2);
		chk_pin("sense", 2'h0);
		w(1);
		chk_pin("again", 2'h2);
		w(8);
		chk("soft", 5'h1C);
		hs = 0;
		w(20);
		chk("soft end", 5'h01);
		chk_pin("soft idle", 2'h0);
	endtask : t_soft
	task t_hard;
		hh = 1;
		w(5);
		chk("hard", 5'h1E);
		chk_pin("hard pin", 2'h0);
		hh = 0;
		w(20);
		chk("hard end", 5'h01);
	endtask : t_hard
	initial
	begin
		w(6);
		reset_n = 1;
		w(9);
		t_soft;
		t_hard;
		stop_test;
	end
	// Whole run is about 80 cycles
	initial
	begin
		#2000;
		n_mismatch++;
		stop_test;
	end
endmodule : tb_dual_pin_reset_controller

// *** verilog/dual_pin_reset_controller.sv ***
// Reset controller for a soft reset pin (two-way) and a hard power reset pin.
// Assumes pin levels arrive asynchronously; outputs are active-high resets per domain.
// Debug, clock and power-on-only state sit outside; only the hard pin clears por_only.
// Parameters set the burst and sense lengths; the sense window needs three or more.
// Operation
// RULE1: Core stays in soft reset while the soft pin is sensed low.
// RULE2: On soft pin release, reset core, digital registers and core-supply peripherals.
// RULE3: Soft reset spares power-on-only registers, clock, debug engine and debugger.
// RULE4: Once soft pin is sensed low, device drives it low itself.
// RULE5: Drive low six cycles, release, sense again, repeat until pin reads high.
// RULE6: While hard pin is sensed low, the whole device is held in reset.
// RULE7: On hard pin release, full power-on reset except the clock, then execute.
// RULE8: Both pin inputs pass a two-flop synchroniser before use.
`timescale 1ns/10ps
`include "reset_ctrl_defs.svh"
module dual_pin_reset_controller #(
	// Length of one drive burst on the soft pin, in system clocks
	parameter int DRIVE_CYCLES = `SOFT_DRIVE_CYCLES,
	// Release window before the pin is judged; three or more covers the synchroniser
	parameter int SENSE_CYCLES = `SOFT_SENSE_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Soft reset pin
	input wire logic soft_reset_pin_n_in,
	output logic soft_reset_pin_n_out,
	output logic soft_reset_pin_n_oe,
	// Hard power reset pin
	input wire logic hard_power_reset_pin_n,
	// Reset outputs
	output reset_ctrl_pkg::reset_group_t reset_out,
	output logic run
);
	// Pin indices into the synchroniser bank
	localparam int PIN_SOFT = 0;
	localparam int PIN_HARD = 1;
	// One counter serves both the drive burst and the sense window
	// Counter width fits the longer of the two windows
	localparam int COUNT_MAX = (DRIVE_CYCLES > SENSE_CYCLES) ? DRIVE_CYCLES : SENSE_CYCLES;
	localparam int COUNT_W = $clog2(COUNT_MAX + 1);
	localparam logic [COUNT_W-1:0] DRIVE_LAST = COUNT_W'(DRIVE_CYCLES - 1);
	localparam logic [COUNT_W-1:0] SENSE_LAST = COUNT_W'(SENSE_CYCLES - 1);

	// Raw pin levels and their synchronised copies
	logic [1:0] pin_raw;
	logic [1:0] pin_level;
	// Sequencer state
	reset_ctrl_pkg::soft_state_t state;
	reset_ctrl_pkg::soft_state_t next_state;
	logic [COUNT_W-1:0] count;
	logic [COUNT_W-1:0] next_count;
	logic next_oe;
	// Reset group outputs
	reset_ctrl_pkg::reset_group_t next_reset_out;
	logic next_run;
	logic next_pin_out;
	// Decoded pin levels and counter ends
	logic soft_low;
	logic hard_low;
	logic drive_done;
	logic sense_done;
	logic seq_busy;

	assign pin_raw = {hard_power_reset_pin_n, soft_reset_pin_n_in};

	// Pins reset to the asserted level: core, digital and peripheral resets stay on until both are seen high
	for (genvar i = 0; i < 2; i++)
	begin : g_sync
		logic first;
		logic second;
		logic next_first;
		logic next_second;

		// First flop may go metastable; only the second is read
		always_comb
		begin
			next_first = pin_raw[i]; // see RULE8
			next_second = first; // see RULE8
		end

		always_ff @(posedge clk or negedge reset_n)
		begin
			if (!reset_n)
			begin
				first <= 1'b0;
				second <= 1'b0;
			end
			else
			begin
				first <= next_first;
				second <= next_second;
			end
		end

		assign pin_level[i] = second;
	end

	assign soft_low = ~pin_level[PIN_SOFT];
	assign hard_low = ~pin_level[PIN_HARD];

	// Counter end points and sequencer activity
	assign drive_done = (count == DRIVE_LAST);
	assign sense_done = (count == SENSE_LAST);
	assign seq_busy = (next_state != reset_ctrl_pkg::st_idle);

	// Soft pin sequencer: drive low, release, sense, repeat while held
	always_comb
	begin
		next_state = state;
		next_count = count;
		next_oe = 1'b0;
		if (hard_low)
		begin
			// Hard pin overrides the soft sequence
			next_state = reset_ctrl_pkg::st_idle; // see RULE6
			next_count = '0;
		end
		else
		begin
			case (state)
				reset_ctrl_pkg::st_idle:
				begin
					if (soft_low)
					begin
						next_state = reset_ctrl_pkg::st_drive; // see RULE4
						next_count = '0;
						next_oe = 1'b1;
					end
				end
				reset_ctrl_pkg::st_drive:
				begin
					if (drive_done)
					begin
						// Release and let the synchroniser see the true pin level
						next_state = reset_ctrl_pkg::st_sense; // see RULE5
						next_count = '0;
					end
					else
					begin
						next_count = count + 1'b1;
						next_oe = 1'b1; // see RULE5
					end
				end
				reset_ctrl_pkg::st_sense:
				begin
					// Two synchroniser cycles plus settling before judging the pin
					if (sense_done)
					begin
						next_count = '0;
						if (soft_low)
						begin
							next_state = reset_ctrl_pkg::st_drive; // see RULE5
							next_oe = 1'b1;
						end
						else
						begin
							next_state = reset_ctrl_pkg::st_idle;
						end
					end
					else
					begin
						next_count = count + 1'b1;
					end
				end
				default:
				begin
					next_state = reset_ctrl_pkg::st_idle;
					next_count = '0;
				end
			endcase
		end
	end

	// Reset group decode; every output leaves through a register
	always_comb
	begin
		// Power-on-only group follows the hard pin alone
		next_reset_out.por_only = hard_low; // see RULE3, RULE6
		// Core, digital and peripheral resets move together
		next_reset_out.core = hard_low | soft_low; // see RULE1
		if (seq_busy)
			next_reset_out.core = 1'b1; // see RULE2
		next_reset_out.digital = next_reset_out.core; // see RULE2
		next_reset_out.periph = next_reset_out.core; // see RULE2
		next_run = ~next_reset_out.core & ~next_reset_out.por_only; // see RULE7
		// Pin value is always low; only the enable varies
		next_pin_out = 1'b0; // see RULE4
	end

	// Sequencer registers
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= reset_ctrl_pkg::st_idle;
			count <= '0;
			soft_reset_pin_n_oe <= 1'b0;
		end
		else
		begin
			state <= next_state;
			count <= next_count;
			soft_reset_pin_n_oe <= next_oe; // see RULE4
		end
	end

	// Reset group and pin value registers
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			reset_out <= `RESET_GROUP_ASSERTED;
			run <= 1'b0;
			soft_reset_pin_n_out <= 1'b0;
		end
		else
		begin
			reset_out <= next_reset_out; // see RULE7
			run <= next_run;
			soft_reset_pin_n_out <= next_pin_out;
		end
	end
endmodule : dual_pin_reset_controller

// *** verilog/reset_ctrl_defs.svh ***
// Timing constants and reset group value for the dual pin reset controller.
// Assumes inclusion by bare name from the design file.
`ifndef RESET_CTRL_DEFS_SVH
`define RESET_CTRL_DEFS_SVH
`define SOFT_DRIVE_CYCLES 6
`define SOFT_SENSE_CYCLES 3
`define RESET_GROUP_ASSERTED 4'hF
`endif

// *** verilog/reset_ctrl_pkg.sv ***
// Types for the dual pin reset controller.
// Assumes nothing of its surroundings.
package reset_ctrl_pkg;
	typedef enum logic [1:0] {
		st_idle,
		st_drive,
		st_sense
	} soft_state_t;

	typedef struct packed {
		logic core;
		logic digital;
		logic periph;
		logic por_only;
	} reset_group_t;
endpackage : reset_ctrl_pkg
